// ==== pkg/opa_pkg.sv ====
/*
  opa_pkg: command codes, status and control bit positions and carrier
  types for the operator panel adapter.
  Assumes one system clock and commands presented one per cycle.
*/
package opa_pkg;
  // ------------------------------------------------------------
  // device address and command codes
  // ------------------------------------------------------------
  localparam logic [7:0] OPA_DEV_ADDR  = 8'h0a;
  localparam logic [7:0] CMD_RESET     = 8'h01;
  localparam logic [7:0] CMD_RD_STAT   = 8'h10;
  localparam logic [7:0] CMD_RD_R1L    = 8'h11;
  localparam logic [7:0] CMD_RD_R1H    = 8'h12;
  localparam logic [7:0] CMD_RD_R2L    = 8'h13;
  localparam logic [7:0] CMD_RD_R2H    = 8'h14;
  localparam logic [7:0] CMD_RD_CTRL   = 8'h15;
  localparam logic [7:0] CMD_WR_STAT   = 8'h20;
  localparam logic [7:0] CMD_SET_STAT  = 8'h21;
  localparam logic [7:0] CMD_CLR_STAT  = 8'h22;
  localparam logic [7:0] CMD_WR_CTRL   = 8'h23;
  localparam logic [7:0] CMD_WR_R1L    = 8'h24;
  localparam logic [7:0] CMD_WR_R1H    = 8'h25;
  localparam logic [7:0] CMD_WR_R2L    = 8'h26;
  localparam logic [7:0] CMD_WR_R2H    = 8'h27;
  localparam logic [7:0] CMD_WR_CMPH   = 8'h28;
  localparam logic [7:0] CMD_WR_CMPL   = 8'h29;
  localparam logic [7:0] CMD_WR_LEVEL  = 8'h2a;
  // ------------------------------------------------------------
  // panel_status_word bits
  // ------------------------------------------------------------
  localparam int ST_STORLOC   = 2;
  localparam int ST_CHECKSTOP = 6;
  localparam int ST_RR0       = 8;
  localparam int ST_RR1       = 9;
  localparam int ST_RR2       = 10;
  localparam int ST_CMP_FETCH = 11;
  localparam int ST_CMP_STORE = 12;
  localparam int ST_PENDING   = 13;
  localparam int ST_IRQ_EN    = 14;
  localparam int ST_RR3       = 15;
  // bits whose being set asks for an interrupt
  localparam logic [15:0] ST_EVENT_MASK = 16'h9f44;
  // ------------------------------------------------------------
  // panel_control bits
  // ------------------------------------------------------------
  localparam int CT_CMP_FETCH = 0;
  localparam int CT_CMP_STORE = 1;
  localparam int CT_CHK_STOP  = 2;
  localparam int CT_REG2_SEL  = 3;
  localparam int CT_ATTN      = 6;
  localparam int CT_KEYLOCK   = 7;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [15:0] STAT_RESET  = 16'h0000;
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [31:0] ENTRY_RESET = 32'h0000_0000;
  localparam logic [3:0]  LEVEL_ANY   = 4'h0;
  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic [7:0]  dev;
    logic [7:0]  code;
    logic [15:0] wdata;
  } opa_cmd_t;
  typedef struct packed {
    logic        valid;
    logic        store;
    logic [2:0]  level;
    logic [31:0] addr;
  } opa_acc_t;
  typedef enum logic [1:0] {OPA_RUN, OPA_STOP, OPA_STEP} opa_run_t;
endpackage : opa_pkg

// ==== rtl/opa_adapter.sv ====
/*
  opa_adapter: operator panel adapter between the host processor and the
  expanded_panel pushbuttons and indicators.
  Assumes all inputs synchronous to clock and button inputs one-cycle
  pulses. Processor accesses are observed on a monitor port.
*/
// How it works
// - reset/restore resets processor, unlocks keys, sets status 8,9,10,15
// - step runs one instruction while stopped, loads address into entry one
// - stop lights stop indicator and halts execution
// - armed check stop halts on check or exception; button sets bit 6
// - only commands at device address 0A are accepted
// - reset-adapter clears every adapter register to zero except the run state
// - separate reads for status, entry halves and control
// - status writable whole, plus set-bits and reset-bits commands
// - enabled interrupt with pending event raises irq and pending bit
// - eight-bit control register written and read back
// - control bit 3 routes keyed entry to entry two, else one
// - entry registers have separately written 16-bit halves
// - keyed digit shifts in low nibble, top nibble lost
// - compare register loaded by halves; level zero matches address only
// - armed compare on matching access sets status and asks interrupt
// - store compare matches only at the compare address
// - unsupported command code reports a system check
// - storage-location button sets status bit 2, selects entry one
`timescale 1ns/100ps
module opa_adapter
  import opa_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // host command port
  input  wire opa_cmd_t    cmd,
  output logic             resp_valid,
  output logic [15:0]      resp_data,
  output logic             sys_check,
  output logic             irq,
  // processor control
  input  wire opa_acc_t    acc,
  input  wire logic        proc_check,
  input  wire logic        step_done,
  input  wire logic [31:0] step_addr,
  output logic             proc_reset,
  output logic             proc_halt,
  output logic             step_req,
  // panel pushbuttons
  input  wire logic        btn_restore,
  input  wire logic        btn_stop,
  input  wire logic        btn_start,
  input  wire logic        btn_step,
  input  wire logic        btn_chkstop,
  input  wire logic        btn_storloc,
  input  wire logic        key_valid,
  input  wire logic [3:0]  key_digit,
  // panel indicators
  output logic [31:0]      disp_value,
  output logic             ind_reg2,
  output logic             ind_stop,
  output logic             ind_chkstop,
  output logic             ind_keylock,
  output logic             ind_attn,
  output logic             storloc_sel,
  output logic [31:0]      storloc_addr
);
  // ------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------
  logic [15:0] panel_status_word;
  logic [7:0]  panel_control;
  logic [31:0] entry_register_one;
  logic [31:0] entry_register_two;
  logic [31:0] cmp_addr;
  logic [3:0]  cmp_level;
  opa_run_t    run_state;
  logic        mine;
  logic        known;
  logic        is_read;
  logic        do_reset;
  logic        keys_ok;
  logic        cmp_hit;
  logic        fetch_hit;
  logic        store_hit;
  logic        chk_hit;

  assign mine     = cmd.valid && (cmd.dev == OPA_DEV_ADDR);
  assign do_reset = mine && (cmd.code == CMD_RESET);
  assign is_read  = (cmd.code >= CMD_RD_STAT) && (cmd.code <= CMD_RD_CTRL);
  assign known    = is_read || do_reset
                 || ((cmd.code >= CMD_WR_STAT) && (cmd.code <= CMD_WR_LEVEL));
  // locked keyboard only lets reset/restore through
  assign keys_ok  = !panel_control[CT_KEYLOCK];

  // ------------------------------------------------------------
  // read answer and system check
  // ------------------------------------------------------------
  // read data registered so it stands clean for one cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      resp_valid <= 1'b0;
      resp_data  <= 16'h0000;
    end else begin
      resp_valid <= mine && is_read;
      if (!(mine && is_read)) begin
        resp_data <= 16'h0000;
      end else if (cmd.code == CMD_RD_STAT) begin
        resp_data <= panel_status_word;
      end else if (cmd.code == CMD_RD_R1L) begin
        resp_data <= entry_register_one[15:0];
      end else if (cmd.code == CMD_RD_R1H) begin
        resp_data <= entry_register_one[31:16];
      end else if (cmd.code == CMD_RD_R2L) begin
        resp_data <= entry_register_two[15:0];
      end else if (cmd.code == CMD_RD_R2H) begin
        resp_data <= entry_register_two[31:16];
      end else begin
        resp_data <= {8'h00, panel_control};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sys_check <= 1'b0;
    end else begin
      sys_check <= mine && !known;
    end
  end

  // ------------------------------------------------------------
  // control and compare registers
  // ------------------------------------------------------------
  // control write
  always_ff @(posedge clock) begin
    if (!rst_n || do_reset) begin
      panel_control <= CTRL_RESET;
    end else if (mine && cmd.code == CMD_WR_CTRL) begin
      panel_control <= cmd.wdata[7:0];
    end else if (btn_restore) begin
      panel_control[CT_KEYLOCK] <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n || do_reset) begin
      cmp_addr  <= ENTRY_RESET;
      cmp_level <= LEVEL_ANY;
    end else if (mine && cmd.code == CMD_WR_CMPH) begin
      cmp_addr[31:16] <= cmd.wdata;
    end else if (mine && cmd.code == CMD_WR_CMPL) begin
      cmp_addr[15:0] <= cmd.wdata;
    end else if (mine && cmd.code == CMD_WR_LEVEL) begin
      cmp_level <= cmd.wdata[3:0];
    end
  end

  assign cmp_hit = acc.valid && (acc.addr == cmp_addr)
                && ((cmp_level == LEVEL_ANY) || (cmp_level[2:0] == acc.level));
  assign store_hit = cmp_hit && acc.store && panel_control[CT_CMP_STORE];
  assign fetch_hit = cmp_hit && !acc.store && panel_control[CT_CMP_FETCH];
  assign chk_hit   = panel_control[CT_CHK_STOP] && (proc_check || sys_check);

  // ------------------------------------------------------------
  // entry registers
  // ------------------------------------------------------------
  // halves written alone
  always_ff @(posedge clock) begin
    if (!rst_n || do_reset) begin
      entry_register_one <= ENTRY_RESET;
    end else if (mine && cmd.code == CMD_WR_R1L) begin
      entry_register_one[15:0] <= cmd.wdata;
    end else if (mine && cmd.code == CMD_WR_R1H) begin
      entry_register_one[31:16] <= cmd.wdata;
    end else if (run_state == OPA_STEP && step_done) begin
      entry_register_one <= step_addr;
    end else if (key_valid && keys_ok && !panel_control[CT_REG2_SEL]) begin
      entry_register_one <= {entry_register_one[27:0], key_digit};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n || do_reset) begin
      entry_register_two <= ENTRY_RESET;
    end else if (mine && cmd.code == CMD_WR_R2L) begin
      entry_register_two[15:0] <= cmd.wdata;
    end else if (mine && cmd.code == CMD_WR_R2H) begin
      entry_register_two[31:16] <= cmd.wdata;
    end else if (key_valid && keys_ok && panel_control[CT_REG2_SEL]) begin
      entry_register_two <= {entry_register_two[27:0], key_digit};
    end
  end

  // ------------------------------------------------------------
  // status register
  // ------------------------------------------------------------
  logic [15:0] next_status;
  logic [15:0] hw_set;

  // hardware sets are or-ed last so a same-cycle clear cannot lose them
  always_comb begin
    hw_set = 16'h0000;
    if (btn_restore) begin
      hw_set[ST_RR0] = 1'b1;
      hw_set[ST_RR1] = 1'b1;
      hw_set[ST_RR2] = 1'b1;
      hw_set[ST_RR3] = 1'b1;
    end
    hw_set[ST_STORLOC]   = btn_storloc && keys_ok;
    hw_set[ST_CHECKSTOP] = btn_chkstop && keys_ok;
    hw_set[ST_CMP_FETCH] = fetch_hit;
    hw_set[ST_CMP_STORE] = store_hit;
    next_status = panel_status_word;
    if (mine && cmd.code == CMD_WR_STAT) begin
      next_status = cmd.wdata;
    end else if (mine && cmd.code == CMD_SET_STAT) begin
      next_status = panel_status_word | cmd.wdata;
    end else if (mine && cmd.code == CMD_CLR_STAT) begin
      next_status = panel_status_word & ~cmd.wdata;
    end
    next_status = next_status | hw_set;
    next_status[ST_PENDING] = next_status[ST_IRQ_EN]
                           && |(next_status & ST_EVENT_MASK);
  end

  always_ff @(posedge clock) begin
    if (!rst_n || do_reset) begin
      panel_status_word <= STAT_RESET;
    end else begin
      panel_status_word <= next_status;
    end
  end

  assign irq = panel_status_word[ST_PENDING];

  // ------------------------------------------------------------
  // run control
  // ------------------------------------------------------------
  // run state kept across reset-adapter: it is processor state, not a register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      run_state <= OPA_RUN;
    end else begin
      case (run_state)
        OPA_RUN: begin
          if ((btn_stop && keys_ok) || fetch_hit || store_hit || chk_hit) begin
            run_state <= OPA_STOP;
          end
        end
        OPA_STOP: begin
          if (btn_step && keys_ok) begin
            run_state <= OPA_STEP;
          end else if (btn_start && keys_ok) begin
            run_state <= OPA_RUN;
          end
        end
        OPA_STEP: begin
          if (step_done) begin
            run_state <= OPA_STOP;
          end
        end
        default: begin
          run_state <= OPA_RUN;
        end
      endcase
    end
  end

  // step request lasts one cycle at entry to stepping
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      step_req   <= 1'b0;
      proc_reset <= 1'b0;
    end else begin
      step_req   <= (run_state == OPA_STOP) && btn_step && keys_ok;
      proc_reset <= btn_restore;
    end
  end

  // ------------------------------------------------------------
  // indicators
  // ------------------------------------------------------------
  assign proc_halt    = (run_state != OPA_RUN);
  assign ind_stop     = proc_halt;
  assign ind_chkstop  = panel_control[CT_CHK_STOP];
  assign ind_keylock  = panel_control[CT_KEYLOCK];
  assign ind_attn     = panel_control[CT_ATTN];
  assign ind_reg2     = panel_control[CT_REG2_SEL];
  assign disp_value   = ind_reg2 ? entry_register_two : entry_register_one;
  assign storloc_sel  = panel_status_word[ST_STORLOC];
  assign storloc_addr = entry_register_one;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  sequence restore_seq;
    btn_restore && rst_n && !do_reset && !(mine && cmd.code == CMD_WR_CTRL);
  endsequence

  sequence restore_done_seq;
    proc_reset && panel_status_word[ST_RR0] && panel_status_word[ST_RR3]
    && !panel_control[CT_KEYLOCK];
  endsequence

  restore_sets_a: assert property (@(posedge clock) disable iff (!rst_n)
    restore_seq |=> restore_done_seq)
    else $error("restore did not set status");

  step_load_a: assert property (@(posedge clock) disable iff (!rst_n)
    (run_state == OPA_STEP && step_done && !do_reset
     && !(mine && (cmd.code == CMD_WR_R1L || cmd.code == CMD_WR_R1H)))
    |=> entry_register_one == $past(step_addr) && run_state == OPA_STOP)
    else $error("step address not loaded");

  stop_halt_a: assert property (@(posedge clock) disable iff (!rst_n)
    (run_state == OPA_RUN && btn_stop && keys_ok) |=> ind_stop && proc_halt)
    else $error("stop did not halt");

  reset_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    do_reset |=> panel_control == CTRL_RESET && entry_register_two == ENTRY_RESET
    && cmp_addr == ENTRY_RESET)
    else $error("reset adapter left data");

  read_answer_a: assert property (@(posedge clock) disable iff (!rst_n)
    (mine && cmd.code == CMD_RD_CTRL) |=> resp_valid
    && resp_data == {8'h00, $past(panel_control)})
    else $error("control read wrong");

  clear_bits_a: assert property (@(posedge clock) disable iff (!rst_n)
    (mine && cmd.code == CMD_CLR_STAT && hw_set == 16'h0000)
    |=> (panel_status_word & $past(cmd.wdata) & 16'h5fff) == 16'h0000)
    else $error("reset-bits left bits set");

  irq_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    (irq && !mine) |=> irq)
    else $error("irq dropped without host");

  bad_code_a: assert property (@(posedge clock) disable iff (!rst_n)
    (mine && !known) ##1 !(mine && !known) |-> sys_check ##1 !sys_check)
    else $error("no system check");

  fetch_cmp_a: assert property (@(posedge clock) disable iff (!rst_n)
    (fetch_hit && !do_reset) |=> panel_status_word[ST_CMP_FETCH] && proc_halt)
    else $error("fetch compare missed");
endmodule : opa_adapter

// ==== test/opa_proc_model.sv ====
/*
  opa_proc_model: behavioural host processor seen by the panel adapter.
  Assumes the bench calls access() and check() just after a rising edge.
*/
`timescale 1ns/100ps
module opa_proc_model
  import opa_pkg::*;
#(
  parameter logic [31:0] STEP_PC = 32'h0001_2346
)(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // adapter control
  input  wire logic        proc_reset,
  input  wire logic        proc_halt,
  input  wire logic        step_req,
  // monitor and results back to the adapter
  output opa_acc_t         acc,
  output logic             proc_check,
  output logic             step_done,
  output logic [31:0]      step_addr
);
  logic [1:0] step_cnt;

  // quiet start so the adapter never samples unknowns
  initial begin
    acc = '0;
    proc_check = 1'b0;
    step_done = 1'b0;
    step_addr = ~STEP_PC;
    step_cnt = 2'd0;
  end

  // a step takes two cycles; the address toggles when not valid
  always @(posedge clock) begin
    step_done <= (step_cnt == 2'd1);
    step_addr <= (step_cnt == 2'd1) ? STEP_PC : ~step_addr;
    if (!rst_n || proc_reset) begin
      step_cnt <= 2'd0;
    end else if (step_req) begin
      step_cnt <= 2'd2;
    end else if (step_cnt != 2'd0) begin
      step_cnt <= step_cnt - 2'd1;
    end
  end

  // one storage access at level 3; released bus shows no stale address
  task automatic access(input logic st, input logic [31:0] a);
    acc = '{1'b1, st, 3'd3, a};
    @(posedge clock);
    #1;
    acc = '{1'b0, 1'b0, 3'd0, ~a};
    // one idle cycle so a following call never reassigns acc in this step
    @(posedge clock);
    #1;
  endtask : access

  // one-cycle system check report
  task automatic check();
    proc_check = 1'b1;
    @(posedge clock);
    #1;
    proc_check = 1'b0;
  endtask : check
endmodule : opa_proc_model

// ==== test/operator_panel_adapter_bench.sv ====
/*
  operator_panel_adapter_bench: self-checking bench for opa_adapter.
  Assumes opa_proc_model stands in for the processor; host commands and
  panel buttons are driven here 1 ns after each rising edge.
*/
`timescale 1ns/100ps
module operator_panel_adapter_bench
  import opa_pkg::*;
;
  localparam logic [31:0] PC = 32'h0001_2346;
  logic        clock, rst_n, resp_valid, sys_check, irq, proc_check, step_done;
  logic        proc_reset, proc_halt, step_req, key_valid, storloc_sel;
  logic        btn_restore, btn_stop, btn_start, btn_step, btn_chkstop, btn_storloc;
  logic        ind_reg2, ind_stop, ind_chkstop, ind_keylock, ind_attn;
  opa_cmd_t    cmd;
  opa_acc_t    acc;
  logic [15:0] resp_data;
  logic [31:0] step_addr, disp_value, storloc_addr;
  logic [3:0]  key_digit;
  logic [7:0]  dev_sel;
  int          err_total, tests_run;
  logic [7:0]  bad [5] = '{8'h00, 8'h02, 8'h16, 8'h2b, 8'hff};
  logic [31:0] cmp_addr [3] = '{32'h0000_fffe, 32'h0003_fffe, 32'h0007_fffe};

  opa_adapter dut (
    .clock, .rst_n, .cmd, .resp_valid, .resp_data, .sys_check, .irq, .acc,
    .proc_check, .step_done, .step_addr, .proc_reset, .proc_halt, .step_req,
    .btn_restore, .btn_stop, .btn_start, .btn_step, .btn_chkstop, .btn_storloc,
    .key_valid, .key_digit, .disp_value, .ind_reg2, .ind_stop, .ind_chkstop,
    .ind_keylock, .ind_attn, .storloc_sel, .storloc_addr
  );
  opa_proc_model #(.STEP_PC(PC)) cpu (
    .clock, .rst_n, .proc_reset, .proc_halt, .step_req, .acc, .proc_check,
    .step_done, .step_addr
  );

  // 100 MHz system clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic wrap_up();
    if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // valid stays up so commands can run back to back
  task automatic issue(input logic [7:0] c, input logic [15:0] d);
    cmd = '{1'b1, dev_sel, c, d};
    @(posedge clock);
    #1;
  endtask : issue

  task automatic idle();
    cmd.valid = 1'b0;
    @(posedge clock);
    #1;
  endtask : idle

  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    issue(c, 16'h0000);
    chk($sformatf("read %h", c), {15'h0, 1'b1, e}, {15'h0, resp_valid, resp_data});
  endtask : rd

  // drops any held command so a button never races a host write
  task automatic press(ref logic b);
    cmd.valid = 1'b0;
    b = 1'b1;
    @(posedge clock);
    #1;
    b = 1'b0;
  endtask : press

  task automatic key(input logic [3:0] d);
    key_digit = d;
    key_valid = 1'b1;
    @(posedge clock);
    #1;
  endtask : key

  task automatic t_regs();
    issue(CMD_WR_CTRL, 16'h00e5);
    rd(CMD_RD_CTRL, 16'h00e5);
    chk("ind_attn", 1'b1, ind_attn);
    chk("ind_keylock", 1'b1, ind_keylock);
    issue(CMD_WR_R1L, 16'h1234);
    issue(CMD_WR_R1H, 16'h5678);
    issue(CMD_WR_R2L, 16'h9abc);
    issue(CMD_WR_R2H, 16'hdef0);
    rd(CMD_RD_R1L, 16'h1234);
    rd(CMD_RD_R1H, 16'h5678);
    rd(CMD_RD_R2L, 16'h9abc);
    rd(CMD_RD_R2H, 16'hdef0);
    chk("disp_value", 32'h5678_1234, disp_value);
    issue(CMD_WR_CTRL, 16'h0008);
    chk("disp_value", 32'hdef0_9abc, disp_value);
    chk("ind_reg2", 1'b1, ind_reg2);
    dev_sel = 8'h0b;
    issue(CMD_WR_CTRL, 16'h0000);
    dev_sel = OPA_DEV_ADDR;
    rd(CMD_RD_CTRL, 16'h0008);
    issue(CMD_RESET, 16'h0000);
    for (int i = 0; i < 6; i++) rd(CMD_RD_STAT + 8'(i), 16'h0000);
    chk("disp_value", 32'h0000_0000, disp_value);
  endtask : t_regs

  task automatic t_keys();
    issue(CMD_WR_R1H, 16'h1234);
    issue(CMD_WR_R1L, 16'h5678);
    idle();
    key(4'h9);
    key(4'ha);
    key_valid = 1'b0;
    chk("entry one", 32'h3456_789a, disp_value);
    issue(CMD_WR_CTRL, 16'h0008);
    idle();
    key(4'h7);
    key_valid = 1'b0;
    rd(CMD_RD_R2L, 16'h0007);
    rd(CMD_RD_R1L, 16'h789a);
  endtask : t_keys

  task automatic t_status();
    issue(CMD_WR_STAT, 16'h00ff);
    rd(CMD_RD_STAT, 16'h00ff);
    issue(CMD_SET_STAT, 16'h0300);
    rd(CMD_RD_STAT, 16'h03ff);
    issue(CMD_CLR_STAT, 16'h0011);
    rd(CMD_RD_STAT, 16'h03ee);
    issue(CMD_WR_STAT, 16'h4000);
    chk("irq", 1'b0, irq);
    issue(CMD_SET_STAT, 16'h0004);
    chk("irq", 1'b1, irq);
    idle();
    idle();
    chk("irq", 1'b1, irq);
    rd(CMD_RD_STAT, 16'h6004);
    issue(CMD_CLR_STAT, 16'h0004);
    chk("irq", 1'b0, irq);
    foreach (bad[i]) begin
      issue(bad[i], 16'h0000);
      chk("sys_check", 1'b1, sys_check);
    end
    rd(CMD_RD_CTRL, 16'h0008);
    chk("sys_check", 1'b0, sys_check);
  endtask : t_status

  task automatic t_step();
    int n;
    idle();
    press(btn_step);
    chk("step_req", 1'b0, step_req);
    press(btn_stop);
    chk("ind_stop", 1'b1, ind_stop);
    chk("proc_halt", 1'b1, proc_halt);
    press(btn_step);
    chk("step_req", 1'b1, step_req);
    for (n = 0; n < 20 && step_done !== 1'b1; n++) begin
      @(posedge clock);
      #1;
    end
    if (n == 20) begin
      err_total++;
      wrap_up();
    end
    @(posedge clock);
    #1;
    rd(CMD_RD_R1L, PC[15:0]);
    rd(CMD_RD_R1H, PC[31:16]);
    chk("proc_halt", 1'b1, proc_halt);
    press(btn_start);
  endtask : t_step

  task automatic t_cmp();
    issue(CMD_WR_LEVEL, 16'h0000);
    issue(CMD_WR_CTRL, 16'h0002);
    foreach (cmp_addr[i]) begin
      issue(CMD_WR_CMPH, cmp_addr[i][31:16]);
      issue(CMD_WR_CMPL, cmp_addr[i][15:0]);
      issue(CMD_WR_STAT, 16'h4000);
      idle();
      cpu.access(1'b0, cmp_addr[i]);
      cpu.access(1'b1, cmp_addr[i] + 32'h0000_0002);
      chk("irq", 1'b0, irq);
      cpu.access(1'b1, cmp_addr[i]);
      chk("proc_halt", 1'b1, proc_halt);
      rd(CMD_RD_STAT, 16'h7000);
      press(btn_start);
    end
    issue(CMD_WR_CTRL, 16'h0001);
    issue(CMD_WR_STAT, 16'h4000);
    idle();
    cpu.access(1'b0, cmp_addr[2]);
    rd(CMD_RD_STAT, 16'h6800);
    press(btn_start);
  endtask : t_cmp

  task automatic t_restore();
    issue(CMD_WR_CTRL, 16'h0084);
    chk("ind_chkstop", 1'b1, ind_chkstop);
    issue(CMD_WR_STAT, 16'h4000);
    press(btn_storloc);
    press(btn_restore);
    chk("proc_reset", 1'b1, proc_reset);
    chk("ind_keylock", 1'b0, ind_keylock);
    chk("irq", 1'b1, irq);
    rd(CMD_RD_STAT, 16'he700);
    rd(CMD_RD_CTRL, 16'h0004);
    issue(CMD_WR_R1L, 16'h4321);
    issue(CMD_WR_STAT, 16'h0000);
    press(btn_storloc);
    chk("storloc_sel", 1'b1, storloc_sel);
    chk("storloc_addr", {PC[31:16], 16'h4321}, storloc_addr);
    rd(CMD_RD_STAT, 16'h0004);
    press(btn_start);
    cpu.check();
    chk("proc_halt", 1'b1, proc_halt);
    issue(CMD_WR_STAT, 16'h0000);
    press(btn_chkstop);
    rd(CMD_RD_STAT, 16'h0040);
    idle();
  endtask : t_restore

  // main sequence: 20 cycles of reset, then one scenario after another
  initial begin
    {btn_restore, btn_stop, btn_start, btn_step, btn_chkstop, btn_storloc} = '0;
    key_valid = 1'b0;
    key_digit = 4'h0;
    cmd = '0;
    dev_sel = OPA_DEV_ADDR;
    err_total = 0;
    tests_run = 0;
    rst_n = 1'b0;
    repeat (20) @(posedge clock);
    #1 rst_n = 1'b1;
    @(posedge clock);
    #1;
    t_regs();
    t_keys();
    t_status();
    t_step();
    t_cmp();
    t_restore();
    wrap_up();
  end

  // hang guard: far beyond the fewer than two hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    wrap_up();
  end
endmodule : operator_panel_adapter_bench
